// file: design/mst_map.svh
`ifndef MST_MAP_SVH
`define MST_MAP_SVH
// Clock rate in MHz
`define MST_CLK_MHZ 20
// Fixed off-time, typical
`define MST_OFF_NS 38000
// Blanking: 1400 ns per nF of timing cap, 680 pF part
`define MST_BLANK_NS 952
// Default fast part of a mixed off-time
`define MST_FAST_NS 9500
// Least times round up, longest round down
`define MST_OFF_CYC ((`MST_OFF_NS * `MST_CLK_MHZ) / 1000)
`define MST_BLANK_CYC ((`MST_BLANK_NS * `MST_CLK_MHZ + 999) / 1000)
`define MST_FAST_CYC ((`MST_FAST_NS * `MST_CLK_MHZ) / 1000)
// Register byte offsets
`define MST_ADDR_OFF 8'h00
`define MST_ADDR_BLANK 8'h04
`define MST_ADDR_FAST 8'h08
`define MST_ADDR_STATUS 8'h0c
`define MST_ADDR_DAC 8'h10
// Translator home position and its DAC level
`define MST_HOME_IDX 6'h08
`define MST_HOME_DAC 8'hb4
// Position increments per step
`define MST_INC_FULL 6'h10
`define MST_INC_HALF 6'h08
`define MST_INC_QUARTER 6'h04
`define MST_INC_SIXTEENTH 6'h01
// Quarter wave span in sixteenth steps
`define MST_QUARTER 5'h10
`define MST_QUARTER_IDX 6'h10
// Decay input trip codes, 0.6 and 0.21 of full scale
`define MST_PFD_HI 8'h9a
`define MST_PFD_LO 8'h36
`endif

// file: design/mst_pkg.sv
package mst_pkg;
	// One full bridge: two high-side and two low-side switches
	typedef struct packed {
		logic srcA;
		logic srcB;
		logic snkA;
		logic snkB;
	} mst_gates_type;
	// Current decay modes
	typedef enum logic [1:0] {DECAY_SLOW, DECAY_FAST, DECAY_MIXED} mst_decay_type;
	// PWM chopper states
	typedef enum logic {PWM_ON, PWM_OFF} mst_pwm_state_type;
	// Status word layout
	typedef struct packed {
		logic [16:0] spare;
		logic gateFault;
		logic lockout;
		logic homeFlag;
		mst_decay_type decay2;
		mst_decay_type decay1;
		logic pol2;
		logic pol1;
		logic [5:0] index;
	} mst_status_type;
endpackage

// file: design/mst_pwm_phase.sv
`timescale 1ns/1ps
`default_nettype none
// Fixed off-time chopper for one full bridge
module mst_pwm_phase (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Control from the translator
	input wire logic driveOk,
	input wire logic polarityPos,
	input wire mst_pkg::mst_decay_type decayMode,
	// Comparator: sensed current reached threshold
	input wire logic senseTrip,
	// Timing in clock cycles
	input wire logic [15:0] offCycles,
	input wire logic [15:0] blankCycles,
	input wire logic [15:0] fastCycles,
	// Bridge switches
	output var mst_pkg::mst_gates_type gates
);
	import mst_pkg::*;

	mst_pwm_state_type state_reg, state_next; // Chopper state
	logic [15:0] cnt_reg, cnt_next; // Blank or off-time counter
	logic pol_reg; // Polarity last driven
	mst_gates_type gates_next;
	wire logic [15:0] cntInc = cnt_reg + 16'h0001;
	wire logic blanking = cnt_reg < blankCycles;
	wire logic polFlip = pol_reg != polarityPos;
	wire logic fastNow = (decayMode == DECAY_FAST) ||
		((decayMode == DECAY_MIXED) && (cnt_reg < fastCycles));

	// Next state, counters and switch pattern
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		gates_next = '0;
		case (state_reg)
			PWM_ON: begin
				// Diagonal pair conducts
				gates_next.srcA = polarityPos;
				gates_next.snkB = polarityPos;
				gates_next.srcB = !polarityPos;
				gates_next.snkA = !polarityPos;
				if (polFlip) begin
					// Switching again restarts the blank
					cnt_next = '0;
				end else if (blanking) begin
					cnt_next = cntInc;
				end else if (senseTrip) begin
					// Latch clears on trip
					state_next = PWM_OFF;
					cnt_next = '0;
				end
			end
			PWM_OFF: begin
				// Slow keeps the low side on; fast drops all
				if (!fastNow) begin
					gates_next.snkB = polarityPos;
					gates_next.snkA = !polarityPos;
				end
				cnt_next = cntInc;
				if (cntInc >= offCycles) begin
					// Off-time over, new on-period
					state_next = PWM_ON;
					cnt_next = '0;
				end
			end
			default: begin
				state_next = PWM_ON;
				cnt_next = '0;
			end
		endcase
		if (!driveOk) begin
			// Bridge off; restart with a blank once allowed
			state_next = PWM_ON;
			cnt_next = '0;
			gates_next = '0;
		end
	end

	// State registers
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= PWM_ON;
			cnt_reg <= '0;
			pol_reg <= 1'b1;
			gates <= '0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			pol_reg <= polarityPos;
			gates <= gates_next;
		end
	end
endmodule
`default_nettype wire

// file: design/mst_translator.sv
// Functional notes
// - step rising edge advances one increment
// - two select pins choose full/half/quarter/sixteenth
// - select changes apply at next step edge
// - direction changes apply at next step edge
// - reset pin homes, bridges off, home low
// - output flags translator at home position
// - reset loads home levels and mixed decay
// - falling level takes decay from decay input
// - equal or rising level uses slow decay
// - per-phase PWM latch, diagonal pair, trip clears
// - slow drops sources, fast drops all, mixed drops all then sources
// - one-shot off-time then new on-period
// - comparator blanked after each switching
// - trip threshold is max scaled by DAC
// - gate regulator fault disables bridges
// - enable gates bridges, translator keeps running
// - decay input classed slow, fast or mixed
// - mixed starts fast then turns slow
// - supply lockout disables bridges and homes
//
// The register offsets and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Offsets, increments and timing defaults by name
`include "mst_map.svh"
// Step translator, decay choice, register view and two choppers
module mst_translator (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Motion controller pins
	// All sampled on mclk; the caller keeps them clean
	input wire logic stepIn,
	input wire logic dirIn,
	input wire logic resolution_sel_a,
	input wire logic resolution_sel_b,
	input wire logic resetInN,
	input wire logic outputEnableN,
	// Decay input level, sampled code of full scale
	input wire logic [7:0] decay_fraction_in,
	// Supervisors
	// Either one drops both bridges within two cycles
	input wire logic supply_low_lockout,
	input wire logic gate_regulator_monitor,
	// Current comparators per phase
	// Ignored while the chopper blanks
	input wire logic senseTrip1,
	input wire logic senseTrip2,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Bridges
	// Registered in the choppers; srcA is the top bit
	output mst_pkg::mst_gates_type bridge1,
	output mst_pkg::mst_gates_type bridge2,
	// DAC levels, polarities and decay per phase
	// Full scale 8'hff; polarity high is positive current
	output logic [7:0] dac1Level,
	output logic [7:0] dac2Level,
	output logic phase1Pos,
	output logic phase2Pos,
	output mst_pkg::mst_decay_type decay1,
	output mst_pkg::mst_decay_type decay2,
	// Home indicator
	output logic homeOut
);
	import mst_pkg::*;

	// Quarter-wave magnitude, full scale 8'hff = 100 %
	// Entry 0 is the crest, entry 16 the zero crossing
	// A case table rather than an array keeps it pure logic
	function automatic logic [7:0] quarterMag(input logic [4:0] k);
		case (k)
			5'h00: quarterMag = 8'hff;
			5'h01: quarterMag = 8'hfe;
			5'h02: quarterMag = 8'hfa;
			5'h03: quarterMag = 8'hf4;
			5'h04: quarterMag = 8'hec;
			5'h05: quarterMag = 8'he1;
			5'h06: quarterMag = 8'hd4;
			5'h07: quarterMag = 8'hc5;
			5'h08: quarterMag = 8'hb4;
			5'h09: quarterMag = 8'ha2;
			5'h0a: quarterMag = 8'h8e;
			5'h0b: quarterMag = 8'h78;
			5'h0c: quarterMag = 8'h62;
			5'h0d: quarterMag = 8'h4a;
			5'h0e: quarterMag = 8'h32;
			5'h0f: quarterMag = 8'h19;
			default: quarterMag = 8'h00;
		endcase
	endfunction

	// Cosine of a position: {positive, level}
	function automatic logic [8:0] cosCode(input logic [5:0] idx);
		logic [4:0] r;
		logic [4:0] rc;
		// Distance from the last crest and to the next zero
		r = {1'b0, idx[3:0]};
		rc = `MST_QUARTER - r;
		// Second and third quadrants drive negative current
		case (idx[5:4])
			2'h0: cosCode = {1'b1, quarterMag(r)};
			2'h1: cosCode = {1'b0, quarterMag(rc)};
			2'h2: cosCode = {1'b0, quarterMag(r)};
			default: cosCode = {1'b1, quarterMag(rc)};
		endcase
	endfunction

	// Decay for a phase after a step
	// Compares magnitudes only; a sign flip alone does not pick the input mode
	function automatic mst_decay_type pickDecay(input logic [7:0] newLvl,
			input logic [7:0] oldLvl, input mst_decay_type fromInput);
		if (newLvl < oldLvl) begin
			pickDecay = fromInput;
		end else begin
			pickDecay = DECAY_SLOW;
		end
	endfunction

	// Translator state
	// Index and levels reset to home together
	logic [5:0] index_reg; // Position in sixteenth steps
	// Resets low like the idle step pin, so no false edge after reset
	logic stepPrev_reg; // Step level one cycle ago
	// Software timing registers
	logic [15:0] offCyc_reg, offCyc_next;
	logic [15:0] blankCyc_reg, blankCyc_next;
	logic [15:0] fastCyc_reg, fastCyc_next;
	// Bus pipeline
	logic wrPend_reg; // Write data phase pending
	logic [7:0] wrAddr_reg; // Its byte offset
	// Chopper enable
	logic driveOk_reg;

	// Step edge and translator hold
	// The detector keeps tracking while homing, so a step held high
	// across a reset release does not fire
	wire logic stepRise = stepIn && !stepPrev_reg;
	wire logic homing = !resetInN || supply_low_lockout;
	wire logic advance = stepRise && !homing;

	// Increment picked from the select pins at the edge
	// Selects between steps are never stored; only the edge cycle counts
	wire logic [1:0] resSel = {resolution_sel_b, resolution_sel_a};
	wire logic [5:0] stepInc = (resSel == 2'h0) ? `MST_INC_FULL :
		(resSel == 2'h1) ? `MST_INC_HALF :
		(resSel == 2'h2) ? `MST_INC_QUARTER :
		`MST_INC_SIXTEENTH;

	// Index wraps modulo 64 by width; direction read at edge only
	// Homing wins over a step that lands in the same cycle
	wire logic [5:0] indexStep = dirIn ? index_reg + stepInc
		: index_reg - stepInc;
	wire logic [5:0] index_next = homing ? `MST_HOME_IDX :
		advance ? indexStep : index_reg;

	// Table look-up; phase 2 is the cosine a quarter back
	// Looked up from the next index so levels move with it, not a cycle late
	wire logic [8:0] code1 = cosCode(index_next);
	wire logic [8:0] code2 = cosCode(index_next - `MST_QUARTER_IDX);

	// Decay input classification
	// Both trip levels are exclusive; the band between is mixed
	wire mst_decay_type pfdMode = (decay_fraction_in > `MST_PFD_HI) ?
		DECAY_SLOW : (decay_fraction_in < `MST_PFD_LO) ? DECAY_FAST :
		DECAY_MIXED;

	// Decay choice per phase on each step
	// Old levels are the registered outputs, so the compare is step to step
	// Between steps the mode holds, whatever the decay input does
	wire mst_decay_type decay1_next = homing ? DECAY_MIXED :
		advance ? pickDecay(code1[7:0], dac1Level, pfdMode) : decay1;
	wire mst_decay_type decay2_next = homing ? DECAY_MIXED :
		advance ? pickDecay(code2[7:0], dac2Level, pfdMode) : decay2;

	// Home flag, forced low while the reset pin is held
	// Under lockout the index is home, so the flag reads high there
	wire logic home_next = resetInN &&
		(index_next == `MST_HOME_IDX);

	// Bridges run only with no fault, no reset, enabled
	// Registered for one clean permission per cycle; costs two cycles to off
	wire logic driveOk_next = !homing && !gate_regulator_monitor &&
		!outputEnableN;

	// Bus decode
	// Only the low address byte is decoded, so the map aliases upward
	// Writes are remembered for the data phase, when hwdata stands
	wire logic addrPhase = hsel && htrans[1] && hready;
	wire logic [7:0] rdAddr = haddr[7:0];
	wire logic wrOff = wrPend_reg && (wrAddr_reg == `MST_ADDR_OFF);
	wire logic wrBlank = wrPend_reg && (wrAddr_reg == `MST_ADDR_BLANK);
	wire logic wrFast = wrPend_reg && (wrAddr_reg == `MST_ADDR_FAST);

	// Timing registers take data-phase write data
	// Upper half of the write word is dropped; the registers are 16 bits
	assign offCyc_next = wrOff ? hwdata[15:0] : offCyc_reg;
	assign blankCyc_next = wrBlank ? hwdata[15:0] : blankCyc_reg;
	assign fastCyc_next = wrFast ? hwdata[15:0] : fastCyc_reg;

	// Status view of the translator
	// Fault and lockout are shown live, not latched
	mst_status_type status;
	assign status.spare = '0;
	assign status.gateFault = gate_regulator_monitor;
	assign status.lockout = supply_low_lockout;
	assign status.homeFlag = homeOut;
	assign status.decay2 = decay2;
	assign status.decay1 = decay1;
	assign status.pol2 = phase2Pos;
	assign status.pol1 = phase1Pos;
	assign status.index = index_reg;

	// Read mux uses next values so a write just before reads back
	// Unmapped offsets read zero
	wire logic [31:0] rdData = (rdAddr == `MST_ADDR_OFF) ? {16'h0000, offCyc_next} :
		(rdAddr == `MST_ADDR_BLANK) ? {16'h0000, blankCyc_next} :
		(rdAddr == `MST_ADDR_FAST) ? {16'h0000, fastCyc_next} :
		(rdAddr == `MST_ADDR_STATUS) ? status :
		(rdAddr == `MST_ADDR_DAC) ? {16'h0000, dac2Level, dac1Level} :
		32'h0000_0000;
	// Captured at the address phase and held through the data phase
	wire logic [31:0] hrdata_next = (addrPhase && !hwrite) ? rdData : hrdata;

	// Edge detector and translator position
	// Home index after reset; the levels below match it
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			stepPrev_reg <= 1'b0;
			index_reg <= `MST_HOME_IDX;
		end else begin
			stepPrev_reg <= stepIn;
			index_reg <= index_next;
		end
	end

	// Phase levels, polarities and decay modes
	// A held index reloads the same table entry, so levels stay put
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			// Home entry, equal on both phases
			dac1Level <= `MST_HOME_DAC;
			dac2Level <= `MST_HOME_DAC;
			phase1Pos <= 1'b1;
			phase2Pos <= 1'b1;
			decay1 <= DECAY_MIXED;
			decay2 <= DECAY_MIXED;
		end else begin
			// DAC code is the threshold scale
			dac1Level <= code1[7:0];
			dac2Level <= code2[7:0];
			phase1Pos <= code1[8];
			phase2Pos <= code2[8];
			decay1 <= decay1_next;
			decay2 <= decay2_next;
		end
	end

	// Home indicator and bridge permission
	// Both bridges stay off until the first permission is registered
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			homeOut <= 1'b1;
			driveOk_reg <= 1'b0;
		end else begin
			homeOut <= home_next;
			driveOk_reg <= driveOk_next;
		end
	end

	// Timing registers; defaults from the nominal RC parts
	// Software may shorten them; an off-time of zero still idles one cycle
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			offCyc_reg <= 16'(`MST_OFF_CYC);
			blankCyc_reg <= 16'(`MST_BLANK_CYC);
			fastCyc_reg <= 16'(`MST_FAST_CYC);
		end else begin
			offCyc_reg <= offCyc_next;
			blankCyc_reg <= blankCyc_next;
			fastCyc_reg <= fastCyc_next;
		end
	end

	// Bus slave: zero wait states, always OKAY
	// Ready and response come off flops, so the bus sees no glitch
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wrPend_reg <= 1'b0;
			wrAddr_reg <= 8'h00;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wrPend_reg <= addrPhase && hwrite;
			wrAddr_reg <= addrPhase ? haddr[7:0] : wrAddr_reg;
			hrdata <= hrdata_next;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Phase 1 chopper; the comparator compares against dac1Level
	mst_pwm_phase phase1Pwm (
		.mclk(mclk),
		.nrst(nrst),
		.driveOk(driveOk_reg),
		.polarityPos(phase1Pos),
		.decayMode(decay1),
		.senseTrip(senseTrip1),
		.offCycles(offCyc_reg),
		.blankCycles(blankCyc_reg),
		.fastCycles(fastCyc_reg),
		.gates(bridge1)
	);

	// Phase 2 chopper
	// Same timing registers as phase 1; the choppers run unsynchronised
	mst_pwm_phase phase2Pwm (
		.mclk(mclk),
		.nrst(nrst),
		.driveOk(driveOk_reg),
		.polarityPos(phase2Pos),
		.decayMode(decay2),
		.senseTrip(senseTrip2),
		.offCycles(offCyc_reg),
		.blankCycles(blankCyc_reg),
		.fastCycles(fastCyc_reg),
		.gates(bridge2)
	);

	// hsize is accepted but ignored; every transfer is served as a whole word
	// Folded to one unused bit so the input counts as read
	wire logic unusedSize = ^hsize;
endmodule
`default_nettype wire

// file: testbench/mst_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// Motion controller: drives step, direction and resolution pins
module mst_ctrl_model #(
	parameter int HIGH_CYC = 20, // 1 us high at 20 MHz
	parameter int LOW_CYC = 20, // 1 us low
	parameter int WAKE_CYC = 20000, // 1 ms before first step
	parameter int SETUP_CYC = 4 // Pins settle well ahead of the edge
) (
	// Clock
	input wire logic mclk,
	// Step link pins
	output logic stepIn,
	output logic dirIn,
	output logic resolution_sel_a,
	output logic resolution_sel_b
);
	// Idle levels from time zero
	initial begin
		stepIn = 1'b0;
		dirIn = 1'b1;
		resolution_sel_a = 1'b0;
		resolution_sel_b = 1'b0;
	end
	// Gate drive must settle before stepping
	task automatic wake();
		repeat (WAKE_CYC) @(posedge mclk);
	endtask
	// Change pins without stepping
	task automatic set_pins(input logic d, input logic [1:0] s);
		@(posedge mclk);
		dirIn <= d;
		resolution_sel_a <= s[0];
		resolution_sel_b <= s[1];
	endtask
	// One pulse; extra stretches the low time like a slow host
	task automatic step(input logic d, input logic [1:0] s, input int extra);
		set_pins(d, s);
		repeat (SETUP_CYC) @(posedge mclk);
		stepIn <= 1'b1;
		repeat (HIGH_CYC) @(posedge mclk);
		stepIn <= 1'b0;
		repeat (LOW_CYC + extra) @(posedge mclk);
	endtask
endmodule
`default_nettype wire

// file: testbench/mst_translator_chk.sv
`timescale 1ns/1ps
`default_nettype none
// Port checks of translator and bridges
module mst_translator_chk (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Controls
	input wire logic stepIn,
	input wire logic resetInN,
	input wire logic outputEnableN,
	input wire logic [7:0] decay_fraction_in,
	input wire logic supply_low_lockout,
	input wire logic gate_regulator_monitor,
	// Watched outputs
	input wire logic hreadyout,
	input wire logic hresp,
	input wire mst_pkg::mst_gates_type bridge1,
	input wire mst_pkg::mst_gates_type bridge2,
	input wire logic [7:0] dac1Level,
	input wire logic [7:0] dac2Level,
	input wire logic phase1Pos,
	input wire logic phase2Pos,
	input wire mst_pkg::mst_decay_type decay1,
	input wire mst_pkg::mst_decay_type decay2,
	input wire logic homeOut
);
	import mst_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	// Step edge the translator accepts
	sequence stepTaken_s;
		resetInN && !supply_low_lockout && $rose(stepIn);
	endsequence
	// Any cause that must hold the bridges off
	sequence bridgeBlock_s;
		outputEnableN || gate_regulator_monitor || supply_low_lockout || !resetInN;
	endsequence
	bus_okay_a: assert property (hreadyout && !hresp) else $error("bus stalled or erred");
	hold_pos_a: assert property (resetInN && !supply_low_lockout && !$rose(stepIn) |=>
		$stable({dac1Level, dac2Level, phase1Pos, phase2Pos})) else $error("moved without step");
	home_match_a: assert property (homeOut |-> dac1Level == 8'hb4 && dac2Level == 8'hb4 &&
		phase1Pos && phase2Pos) else $error("home flag off home levels");
	pin_reset_a: assert property (!resetInN |=> !homeOut && dac1Level == 8'hb4 &&
		decay1 == DECAY_MIXED && decay2 == DECAY_MIXED) else $error("reset pin not homing");
	lockout_home_a: assert property (supply_low_lockout && resetInN |=> homeOut)
		else $error("lockout not homing");
	bridges_off_a: assert property (bridgeBlock_s |-> ##2 bridge1 == 4'h0 && bridge2 == 4'h0)
		else $error("bridge on while blocked");
	rise_slow_a: assert property (stepTaken_s |=> dac1Level < $past(dac1Level) ||
		decay1 == DECAY_SLOW) else $error("rising level not slow");
	fall_fast_a: assert property (stepTaken_s ##0 decay_fraction_in < 8'h36 |=>
		dac2Level >= $past(dac2Level) || decay2 == DECAY_FAST) else $error("falling not fast");
	diag_pair_a: assert property ((bridge1.srcA |-> bridge1.snkB && !bridge1.snkA) and
		(bridge1.srcB |-> bridge1.snkA && !bridge1.snkB)) else $error("bridge not diagonal");
endmodule
bind mst_translator mst_translator_chk u_mst_translator_chk (.mclk, .nrst, .stepIn, .resetInN,
	.outputEnableN, .decay_fraction_in, .supply_low_lockout, .gate_regulator_monitor, .hreadyout,
	.hresp, .bridge1, .bridge2, .dac1Level, .dac2Level, .phase1Pos, .phase2Pos, .decay1, .decay2,
	.homeOut);
`default_nettype wire

// file: testbench/mst_translator_tb.sv
`timescale 1ns/1ps
`default_nettype none
// Bench: step model with integers against the design
module mst_translator_tb;
	import mst_pkg::*;
	// Clock, reset, tallies
	logic mclk = 0;
	logic nrst = 0;
	int n_mismatch = 0;
	int num_checks = 0;
	int cyc = 0;
	int idx = 8; // Model position
	mst_decay_type ed1 = DECAY_MIXED;
	mst_decay_type ed2 = DECAY_MIXED;
	// Design pins
	logic stepIn, dirIn, resolution_sel_a, resolution_sel_b;
	logic resetInN = 1, outputEnableN = 0, supply_low_lockout = 0, gate_regulator_monitor = 0;
	logic senseTrip1 = 0, senseTrip2 = 0, hsel = 0, hwrite = 0, hready;
	logic [7:0] decay_fraction_in = 8'h80;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, phase1Pos, phase2Pos, homeOut;
	logic [7:0] dac1Level, dac2Level;
	mst_gates_type bridge1, bridge2;
	mst_decay_type decay1, decay2;
	mst_status_type st;
	int n0, n1, nOn;
	// Quarter wave of the current table
	logic [7:0] q [17] = '{8'hff, 8'hfe, 8'hfa, 8'hf4, 8'hec, 8'he1, 8'hd4, 8'hc5, 8'hb4,
		8'ha2, 8'h8e, 8'h78, 8'h62, 8'h4a, 8'h32, 8'h19, 8'h00};
	assign hready = hreadyout; // Sole slave drives bus ready
	always #25 mclk = ~mclk;
	mst_ctrl_model u_mst_ctrl_model (.mclk, .stepIn, .dirIn, .resolution_sel_a, .resolution_sel_b);
	mst_translator u_mst_translator (.mclk, .nrst, .stepIn, .dirIn, .resolution_sel_a,
		.resolution_sel_b, .resetInN, .outputEnableN, .decay_fraction_in, .supply_low_lockout,
		.gate_regulator_monitor, .senseTrip1, .senseTrip2, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready, .hrdata, .hreadyout, .hresp, .bridge1, .bridge2, .dac1Level, .dac2Level,
		.phase1Pos, .phase2Pos, .decay1, .decay2, .homeOut);
	// Cosine of a position: {positive, magnitude}
	function automatic logic [8:0] cosv(input int i);
		int k;
		k = i & 63;
		if (k <= 16) return {1'b1, q[k]};
		if (k < 32) return {1'b0, q[32 - k]};
		if (k <= 48) return {1'b0, q[k - 32]};
		return {1'b1, q[64 - k]};
	endfunction
	// Class of the decay input code
	function automatic mst_decay_type cls(input logic [7:0] d);
		return (d > 8'h9a) ? DECAY_SLOW : (d < 8'h36) ? DECAY_FAST : DECAY_MIXED;
	endfunction
	// Count and report one comparison
	task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	// Compare translator outputs with the model
	task automatic check_all(input logic hm);
		logic [8:0] e1, e2;
		e1 = cosv(idx);
		e2 = cosv(idx - 16);
		chk("dac1", dac1Level, e1[7:0]);
		chk("dac2", dac2Level, e2[7:0]);
		if (e1[7:0] != 0) chk("pol1", phase1Pos, e1[8]);
		if (e2[7:0] != 0) chk("pol2", phase2Pos, e2[8]);
		chk("decay1", decay1, ed1);
		chk("decay2", decay2, ed2);
		chk("home", homeOut, hm);
	endtask
	// One modelled step; size from the selects
	task automatic do_step(input logic d, input logic [1:0] s, input logic [7:0] df);
		logic [8:0] o1, o2, n1v, n2v;
		int inc;
		o1 = cosv(idx);
		o2 = cosv(idx - 16);
		inc = (s == 0) ? 16 : (s == 1) ? 8 : (s == 2) ? 4 : 1;
		decay_fraction_in <= df;
		u_mst_ctrl_model.step(d, s, $urandom % 3);
		idx = (idx + (d ? inc : -inc)) & 63;
		n1v = cosv(idx);
		n2v = cosv(idx - 16);
		ed1 = (n1v[7:0] < o1[7:0]) ? cls(df) : DECAY_SLOW;
		ed2 = (n2v[7:0] < o2[7:0]) ? cls(df) : DECAY_SLOW;
		check_all(idx == 8);
	endtask
	// Single AHB-Lite word transfer
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge mclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge mclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	// Counts, verdict, end of run
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Hang guard
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	// Main sequence
	initial begin
		void'($urandom(32'ha3d3836a));
		repeat (10) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		check_all(1'b1);
		u_mst_ctrl_model.wake();
		ahb(0, 8'h00, 0);
		chk("offReg", rd, 760);
		ahb(0, 8'h04, 0);
		chk("blankReg", rd, 20);
		ahb(0, 8'h14, 0);
		chk("unmapped", rd, 0);
		$display("test defaults done");
		// Every resolution, random direction and decay input
		for (int i = 0; i < 48; i++) do_step($urandom % 2, i % 4, $urandom % 256);
		ahb(0, 8'h0c, 0);
		st = rd;
		chk("statIdx", st.index, idx[5:0]);
		u_mst_ctrl_model.set_pins(~dirIn, 2'h3);
		repeat (30) @(posedge mclk);
		check_all(idx == 8);
		$display("test stepping done");
		// Steps ignored under the reset pin
		resetInN <= 1'b0;
		u_mst_ctrl_model.step(1'b1, 2'h0, 0);
		idx = 8;
		ed1 = DECAY_MIXED;
		ed2 = DECAY_MIXED;
		check_all(1'b0);
		resetInN <= 1'b1;
		do_step(1'b1, 2'h3, 8'h10);
		supply_low_lockout <= 1'b1;
		repeat (3) @(posedge mclk);
		idx = 8;
		ed1 = DECAY_MIXED;
		ed2 = DECAY_MIXED;
		check_all(1'b1);
		$display("test reset pins done");
		// Short chopper timing: off 8, blank 2, fast 3
		ahb(1, 8'h00, 8);
		ahb(1, 8'h04, 2);
		ahb(1, 8'h08, 3);
		ahb(0, 8'h08, 0);
		chk("fastReg", rd, 3);
		supply_low_lockout <= 1'b0;
		while (bridge1 !== 4'h9) @(posedge mclk);
		senseTrip1 <= 1'b1;
		senseTrip2 <= 1'b1;
		{n0, n1, nOn} = 0;
		while (bridge1 === 4'h9) @(posedge mclk);
		for (; bridge1 === 4'h0; n0++) @(posedge mclk);
		for (; bridge1 === 4'h1; n1++) @(posedge mclk);
		chk("reOn", bridge1, 4'h9);
		for (; bridge1 === 4'h9; nOn++) @(posedge mclk);
		// Blank of 2, then the held trip ends the third on-cycle
		chk("fastLen", n0, 3);
		chk("offLen", n0 + n1, 8);
		chk("blankLen", nOn, 3);
		{senseTrip1, senseTrip2} <= 2'b00;
		outputEnableN <= 1'b1;
		do_step(1'b0, 2'h1, 8'hc0);
		chk("oeOff", bridge1, 4'h0);
		outputEnableN <= 1'b0;
		gate_regulator_monitor <= 1'b1;
		repeat (3) @(posedge mclk);
		chk("faultOff", bridge2, 4'h0);
		gate_regulator_monitor <= 1'b0;
		senseTrip1 <= 1'b1;
		// Slow decay keeps only the low-side switch on for the whole off-time
		while (bridge1 !== 4'h9) @(posedge mclk);
		while (bridge1 === 4'h9) @(posedge mclk);
		for (n1 = 0; bridge1 === 4'h1; n1++) @(posedge mclk);
		chk("slowOff", n1, 8);
		senseTrip1 <= 1'b0;
		ahb(0, 8'h10, 0);
		chk("dacWord", rd, {16'h0, 8'(cosv(idx - 16)), 8'(cosv(idx))});
		$display("test bridges done");
		give_verdict();
	end
endmodule
`default_nettype wire
